// *** taskfile_defs.vh ***
// Purpose: Constants for the task-file status and command block
// Assumes: 8-bit register data on the low byte of the data pins
// Notes:   Offsets are the DA2..DA0 codes under the given chip selects
`ifndef TASKFILE_DEFS_VH
`define TASKFILE_DEFS_VH
`define TF_DATA       3'h0
`define TF_ERRFEAT    3'h1
`define TF_SCOUNT     3'h2
`define TF_SNUM       3'h3
`define TF_CYLLO      3'h4
`define TF_CYLHI      3'h5
`define TF_DEVHEAD    3'h6
`define TF_STATCMD    3'h7
`define TF_ALTCTL     3'h6
`define ST_BSY        7
`define ST_DRDY       6
`define ST_DWF        5
`define ST_DSC        4
`define ST_DRQ        3
`define ST_CORRECTED_DATA_FLAG       2
`define ST_IDX        1
`define ST_ERR        0
`define DC_SRST       2
`define DC_NIEN       1
`define DH_DEV        4
`define ER_ABRT       2
`define PROTO_PIN     2'h0
`define PROTO_POUT    2'h1
`define PROTO_DMA     2'h2
`define PROTO_ND      2'h3
`define VALID_NS      400
`define CLK_NS        20
`define VALID_CYC     (`VALID_NS / `CLK_NS)
`endif

// *** taskfile_status_cmd.v ***
// Purpose: Status, device control and command decode of a disk task file
// Assumes: Host pins are asynchronous; back-end signals share ref_clk_i
// Notes:   Pin accesses act on the synchronised strobe edges
// How it works
// R1 - Status bits are refreshed whenever a command finishes.
// R2 - Host ignores status while busy; bits valid within 400 ns after busy clears.
// R3 - Reading primary status clears a pending interrupt.
// R4 - Status bits from 7 down: busy, ready, fault, seek, request, corrected, index, error.
// R5 - Error bit set when a command fails; cause sits in error register.
// R6 - Index bit is set once every disk revolution.
// R7 - Corrected-data bit set on a corrected error; transfer goes on.
// R8 - Data request bit only while ready to move data.
// R9 - Seek-complete bit set when the head is on track.
// R10 - After an error, seek, fault and ready bits hold until status read.
// R11 - Write-fault bit set when a write operation fails.
// R12 - Ready bit clear after power-on until commands can be accepted.
// R13 - Host leaves command block registers alone while busy.
// R14 - Command block reads while busy return the status byte.
// R15 - Writing the command register starts that command.
// R16 - Alternate status mirrors status and leaves interrupts pending.
// R17 - Control byte: soft reset bit 2, interrupt disable bit 1.
// R18 - Interrupt line driven only when selected and enabled, else floating.
// R19 - Device held in reset while the soft reset bit is set.
// R20 - Both devices on the cable take the same soft reset.
// R21 - Host loads parameters before writing the command code.
// R22 - Each code sorts into PIO in, PIO out, DMA or non-data.
// R23 - Only parameters valid for the command are used; device-only uses select.
// R24 - B0h health functions by subcode; D4h off-line, D5h/D6h log sectors.
// R25 - F9h protected-area functions by subcode 00h to 04h.
// R26 - B1h configuration overlay by subcode C0h to C3h.
// R27 - 90h diagnostic and 91h geometry are non-data commands.
// R28 - Unsupported codes end with abort and error bits set.
// R29 - Device-select bit picks device 0 or device 1.
// R30 - Busy set on command write until status is valid.
`include "taskfile_defs.vh"
`default_nettype none
module taskfile_status_cmd (
  input  wire        ref_clk_i,
  input  wire        srst_i,
  input  wire        ce_i,
  input  wire        cs0_n_i,
  input  wire        cs1_n_i,
  input  wire [2:0]  da_i,
  input  wire        dior_n_i,
  input  wire        diow_n_i,
  input  wire [7:0]  dd_i,
  input  wire        dev_id_i,
  input  wire        ready_i,
  input  wire        cmd_done_i,
  input  wire        cmd_err_i,
  input  wire        xfer_rdy_i,
  input  wire        corrected_i,
  input  wire        index_i,
  input  wire        on_track_i,
  input  wire        wr_err_i,
  output reg  [7:0]  dd_o,
  output reg         dd_oe_o,
  output reg         intrq_o,
  output reg         intrq_oe_o,
  output reg         cmd_start_o,
  output reg  [7:0]  cmd_code_o,
  output reg  [1:0]  cmd_proto_o,
  output reg  [7:0]  cmd_feat_o,
  output reg  [7:0]  cmd_count_o,
  output reg  [7:0]  cmd_sector_o,
  output reg  [15:0] cmd_cyl_o,
  output reg  [3:0]  cmd_head_o,
  output reg         cmd_lba_o,
  output reg         err_abort_o,
  output reg         soft_reset_o
);
  // Returns {supported, protocol[1:0], valid FR SC SN CY DH}; DH clear means
  // only the device-select bit counts
  function [7:0] decode;
    input [7:0] c;
    input [7:0] f;
    begin
      decode = 8'h00;
      casez (c)
        8'he4, 8'hec: decode = {1'b1, `PROTO_PIN, 5'b00000};
        8'h2?, 8'hc4: decode = (c[3:2] == 2'b00 || c == 8'hc4) ?
          {1'b1, `PROTO_PIN, 5'b01111} : 8'h00;
        8'hc8, 8'hc9, 8'hca, 8'hcb: decode = {1'b1, `PROTO_DMA, 5'b01111};
        8'h40, 8'h41: decode = {1'b1, `PROTO_ND, 5'b01111};
        8'he8: decode = {1'b1, `PROTO_POUT, 5'b00000};
        8'h30, 8'h31, 8'h32, 8'h33, 8'hc5:
          decode = {1'b1, `PROTO_POUT, 5'b01111};
        8'h50: decode = {1'b1, `PROTO_POUT, 5'b01011};
        8'h1?, 8'he7, 8'h90, 8'h95, 8'he1, 8'h99, 8'he6, 8'h94, 8'he0,
        8'hf3, 8'hf5, 8'hf8: decode = {1'b1, `PROTO_ND, 5'b00000}; // see R27
        8'h7?: decode = {1'b1, `PROTO_ND, 5'b00111};
        8'h91: decode = {1'b1, `PROTO_ND, 5'b01001}; // see R27
        8'hef: decode = {1'b1, `PROTO_ND, 5'b10000};
        8'hc6, 8'h98, 8'he5, 8'h97, 8'he3, 8'h96, 8'he2:
          decode = {1'b1, `PROTO_ND, 5'b01000};
        8'hf1, 8'hf2, 8'hf4, 8'hf6: decode = {1'b1, `PROTO_POUT, 5'b00000};
        8'hb0: begin // see R24
          if (f == 8'hd2 || f == 8'hdb)
            decode = {1'b1, `PROTO_ND, 5'b11010};
          else if (f == 8'hd3 || f == 8'hd4 || (f >= 8'hd8 && f <= 8'hda))
            decode = {1'b1, `PROTO_ND, 5'b10010};
          else if (f == 8'hd5)
            decode = {1'b1, `PROTO_PIN, 5'b11110};
          else if (f == 8'hd6)
            decode = {1'b1, `PROTO_POUT, 5'b11110};
        end
        8'hf9: begin // see R25
          if (f == 8'h00)
            decode = {1'b1, `PROTO_ND, 5'b11110};
          else if (f == 8'h01 || f == 8'h03)
            decode = {1'b1, `PROTO_POUT, 5'b10000};
          else if (f == 8'h02 || f == 8'h04)
            decode = {1'b1, `PROTO_ND, 5'b10000};
        end
        8'hb1: begin // see R26
          if (f == 8'hc0 || f == 8'hc1)
            decode = {1'b1, `PROTO_ND, 5'b10000};
          else if (f == 8'hc2)
            decode = {1'b1, `PROTO_PIN, 5'b10000};
          else if (f == 8'hc3)
            decode = {1'b1, `PROTO_POUT, 5'b10000};
        end
        default: decode = 8'h00; // see R22
      endcase
    end
  endfunction

  // Two-stage synchronisers; a third stage gives the strobe edges
  reg [15:0] s1_r;
  reg [15:0] s2_r;
  reg        rd_d_r;
  reg        wr_d_r;
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      s1_r   <= 16'h0fff;
      s2_r   <= 16'h0fff;
      rd_d_r <= 1'b1;
      wr_d_r <= 1'b1;
    end else if (ce_i) begin
      s1_r   <= {dd_i, dev_id_i, da_i, cs0_n_i, cs1_n_i, dior_n_i, diow_n_i};
      s2_r   <= s1_r;
      rd_d_r <= s2_r[1];
      wr_d_r <= s2_r[0];
    end
  end
  wire [7:0] din      = s2_r[15:8];
  wire       own_id   = s2_r[7];
  wire [2:0] addr     = s2_r[6:4];
  wire       cmd_blk  = !s2_r[3] && s2_r[2];
  wire       ctl_blk  = s2_r[3] && !s2_r[2] && addr == `TF_ALTCTL;
  wire       rd_fall  = rd_d_r && !s2_r[1];
  wire       rd_rise  = !rd_d_r && s2_r[1];
  wire       wr_fall  = wr_d_r && !s2_r[0];

  reg [7:0] feat_r;
  reg [7:0] count_r;
  reg [7:0] sector_r;
  reg [7:0] cyl_lo_r;
  reg [7:0] cyl_hi_r;
  reg [7:0] devhead_r;
  reg       nien_r;
  reg       srst_bit_r;
  reg       bsy_r;
  reg       drdy_r;
  reg       dwf_r;
  reg       dsc_r;
  reg       drq_r;
  reg       corrected_data_flag_r;
  reg       idx_r;
  reg       err_r;
  reg       hold_r;
  reg       pend_r;
  reg       abort_r;
  reg       idx_d_r;

  wire selected = devhead_r[`DH_DEV] == own_id; // see R29
  wire sel_wr   = wr_fall && cmd_blk;
  wire cmd_wr   = sel_wr && addr == `TF_STATCMD && selected && !bsy_r;
  wire st_rd    = rd_fall && cmd_blk && addr == `TF_STATCMD && selected;
  wire [7:0] status_byte = {bsy_r, drdy_r, dwf_r, dsc_r,
                            drq_r, corrected_data_flag_r, idx_r, err_r}; // see R4
  wire [7:0] dec  = decode(din, feat_r);
  wire       fin  = bsy_r && cmd_done_i;
  wire       rst  = srst_i || srst_bit_r; // see R19

  // Parameter and control writes; control is accepted regardless of select
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      feat_r     <= 8'h00;
      count_r    <= 8'h00;
      sector_r   <= 8'h00;
      cyl_lo_r   <= 8'h00;
      cyl_hi_r   <= 8'h00;
      devhead_r  <= 8'h00;
      nien_r     <= 1'b0;
      srst_bit_r <= 1'b0;
    end else if (ce_i) begin
      if (wr_fall && ctl_blk) begin
        srst_bit_r <= din[`DC_SRST]; // see R17, R20
        nien_r     <= din[`DC_NIEN]; // see R17
      end
      // Both devices track parameter writes; busy blocks them like the host
      if (sel_wr && !bsy_r && !srst_bit_r) begin // see R13, R21
        if (addr == `TF_ERRFEAT)
          feat_r <= din;
        else if (addr == `TF_SCOUNT)
          count_r <= din;
        else if (addr == `TF_SNUM)
          sector_r <= din;
        else if (addr == `TF_CYLLO)
          cyl_lo_r <= din;
        else if (addr == `TF_CYLHI)
          cyl_hi_r <= din;
        else if (addr == `TF_DEVHEAD)
          devhead_r <= din;
      end
    end
  end

  // Status state; soft reset also clears it but not the control bits
  always @(posedge ref_clk_i) begin
    if (rst) begin
      bsy_r   <= 1'b0;
      drdy_r  <= 1'b0; // see R12
      dwf_r   <= 1'b0;
      dsc_r   <= 1'b0;
      drq_r   <= 1'b0;
      corrected_data_flag_r  <= 1'b0;
      idx_r   <= 1'b0;
      err_r   <= 1'b0;
      hold_r  <= 1'b0;
      pend_r  <= 1'b0;
      abort_r <= 1'b0;
      idx_d_r <= 1'b0;
    end else if (ce_i) begin
      idx_d_r <= index_i;
      idx_r   <= index_i && !idx_d_r; // see R6
      if (cmd_wr) begin
        bsy_r   <= dec[7]; // see R15, R30
        abort_r <= !dec[7]; // see R28
        err_r   <= !dec[7]; // see R28
        drq_r   <= 1'b0;
        corrected_data_flag_r  <= 1'b0;
        hold_r  <= !dec[7];
      end else if (fin) begin
        // Busy and the other bits change in one edge, well inside 400 ns
        bsy_r <= 1'b0; // see R1, R2
        err_r <= cmd_err_i; // see R5
        if (cmd_err_i)
          hold_r <= 1'b1; // see R10
      end else if (st_rd && !bsy_r) begin
        hold_r <= 1'b0; // see R10
      end
      if (!bsy_r || cmd_done_i)
        drq_r <= xfer_rdy_i && !cmd_wr; // see R8
      if (corrected_i && bsy_r)
        corrected_data_flag_r <= 1'b1; // see R7
      if (!hold_r) begin
        drdy_r <= ready_i; // see R12, R10
        dwf_r  <= wr_err_i; // see R11, R10
        dsc_r  <= on_track_i; // see R9, R10
      end
      // A new completion in the read cycle wins over the acknowledge
      if (fin || (xfer_rdy_i && !drq_r && bsy_r))
        pend_r <= 1'b1;
      else if (st_rd)
        pend_r <= 1'b0; // see R3
    end
  end

  // Command hand-off to the back end with masked parameters
  always @(posedge ref_clk_i) begin
    if (rst) begin
      cmd_start_o  <= 1'b0;
      cmd_code_o   <= 8'h00;
      cmd_proto_o  <= `PROTO_ND;
      cmd_feat_o   <= 8'h00;
      cmd_count_o  <= 8'h00;
      cmd_sector_o <= 8'h00;
      cmd_cyl_o    <= 16'h0000;
      cmd_head_o   <= 4'h0;
      cmd_lba_o    <= 1'b0;
    end else if (ce_i) begin
      cmd_start_o <= cmd_wr && dec[7]; // see R15
      if (cmd_wr && dec[7]) begin
        cmd_code_o   <= din;
        cmd_proto_o  <= dec[6:5]; // see R22
        cmd_feat_o   <= dec[4] ? feat_r : 8'h00; // see R23
        cmd_count_o  <= dec[3] ? count_r : 8'h00;
        cmd_sector_o <= dec[2] ? sector_r : 8'h00;
        cmd_cyl_o    <= dec[1] ? {cyl_hi_r, cyl_lo_r} : 16'h0000;
        cmd_head_o   <= dec[0] ? devhead_r[3:0] : 4'h0;
        cmd_lba_o    <= dec[0] && devhead_r[6];
      end
    end
  end

  // Read data: busy forces status onto every command block read
  reg [7:0] rd_data;
  always @* begin
    rd_data = 8'h00;
    if (ctl_blk)
      rd_data = status_byte; // see R16
    else if (bsy_r)
      rd_data = status_byte; // see R14
    else if (addr == `TF_ERRFEAT)
      rd_data = {5'h00, abort_r, 2'h0};
    else if (addr == `TF_SCOUNT)
      rd_data = count_r;
    else if (addr == `TF_SNUM)
      rd_data = sector_r;
    else if (addr == `TF_CYLLO)
      rd_data = cyl_lo_r;
    else if (addr == `TF_CYLHI)
      rd_data = cyl_hi_r;
    else if (addr == `TF_DEVHEAD)
      rd_data = devhead_r;
    else if (addr == `TF_STATCMD)
      rd_data = status_byte;
  end

  // Data register is handled elsewhere, so that address drives here only while busy
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      dd_o         <= 8'h00;
      dd_oe_o      <= 1'b0;
      intrq_o      <= 1'b0;
      intrq_oe_o   <= 1'b0;
      err_abort_o  <= 1'b0;
      soft_reset_o <= 1'b0;
    end else if (ce_i) begin
      if (rd_fall && selected && (ctl_blk ||
          (cmd_blk && (bsy_r || addr != `TF_DATA)))) begin
        dd_o    <= rd_data;
        dd_oe_o <= 1'b1;
      end else if (rd_rise) begin
        dd_oe_o <= 1'b0;
      end
      intrq_o      <= pend_r;
      intrq_oe_o   <= selected && !nien_r; // see R18
      err_abort_o  <= abort_r;
      soft_reset_o <= srst_bit_r; // see R19
    end
  end
endmodule // taskfile_status_cmd
`default_nettype wire

// *** taskfile_status_cmd_props.sv ***
// Purpose: Port assertions for the task-file status and command block
// Assumes: One clock domain, srst_i synchronous and active high
// Notes:   Parameter zeroing is checked on a device-only command
`include "taskfile_defs.vh"
`default_nettype none
module taskfile_status_cmd_props (
  input wire logic        ref_clk_i,
  input wire logic        srst_i,
  input wire logic        intrq_o,
  input wire logic        cmd_start_o,
  input wire logic [7:0]  cmd_code_o,
  input wire logic [1:0]  cmd_proto_o,
  input wire logic [7:0]  cmd_feat_o,
  input wire logic [7:0]  cmd_count_o,
  input wire logic [7:0]  cmd_sector_o,
  input wire logic [15:0] cmd_cyl_o,
  input wire logic [3:0]  cmd_head_o,
  input wire logic        err_abort_o,
  input wire logic        soft_reset_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_one_pulse; cmd_start_o ##1 !cmd_start_o; endsequence
  sequence s_diag; cmd_start_o && cmd_code_o == 8'h90; endsequence
  property p_start_pulse; cmd_start_o |-> s_one_pulse; endproperty
  property p_diag_nd; s_diag |-> cmd_proto_o == `PROTO_ND; endproperty
  property p_dev_only;
    s_diag |-> {cmd_feat_o, cmd_count_o, cmd_sector_o, cmd_cyl_o, cmd_head_o} == 44'h0;
  endproperty
  property p_dco_set;
    cmd_start_o && cmd_code_o == 8'hb1 && cmd_feat_o == 8'hc3 |-> cmd_proto_o == `PROTO_POUT;
  endproperty
  property p_log_rd;
    cmd_start_o && cmd_code_o == 8'hb0 && cmd_feat_o == 8'hd5 |-> cmd_proto_o == `PROTO_PIN;
  endproperty
  property p_max_lock;
    cmd_start_o && cmd_code_o == 8'hf9 && cmd_feat_o == 8'h02 |-> cmd_proto_o == `PROTO_ND;
  endproperty
  property p_abort; $rose(err_abort_o) |-> !cmd_start_o; endproperty
  property p_srst_quiet;
    soft_reset_o && $past(soft_reset_o) |-> !intrq_o && !cmd_start_o && !err_abort_o;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle");
  a_diag_nd: assert property (p_diag_nd) else $error("diag protocol wrong");
  a_dev_only: assert property (p_dev_only) else $error("unused parameter passed");
  a_dco_set: assert property (p_dco_set) else $error("overlay set protocol wrong");
  a_log_rd: assert property (p_log_rd) else $error("log read protocol wrong");
  a_max_lock: assert property (p_max_lock) else $error("max lock protocol wrong");
  a_abort: assert property (p_abort) else $error("abort with start");
  a_srst_quiet: assert property (p_srst_quiet) else $error("activity in soft reset");
endmodule // taskfile_status_cmd_props
bind taskfile_status_cmd taskfile_status_cmd_props u_taskfile_status_cmd_props (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .intrq_o(intrq_o), .cmd_start_o(cmd_start_o),
  .cmd_code_o(cmd_code_o), .cmd_proto_o(cmd_proto_o), .cmd_feat_o(cmd_feat_o),
  .cmd_count_o(cmd_count_o), .cmd_sector_o(cmd_sector_o), .cmd_cyl_o(cmd_cyl_o),
  .cmd_head_o(cmd_head_o), .err_abort_o(err_abort_o), .soft_reset_o(soft_reset_o));
`default_nettype wire

// *** host_port_model.sv ***
// Purpose: Host controller model driving the task-file pins
// Assumes: Fixed strobe timing, no ready handshake on these pins
// Notes:   Released write data is inverted so a stale byte never looks valid
`default_nettype none
module host_port_model (
  input  wire logic       ref_clk_i,
  input  wire logic [7:0] rdata_i,
  output var  logic       cs0_n_o,
  output var  logic       cs1_n_o,
  output var  logic [2:0] da_o,
  output var  logic       dior_n_o,
  output var  logic       diow_n_o,
  output var  logic [7:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {cs0_n_o, cs1_n_o, dior_n_o, diow_n_o} = 4'hf;
    da_o = 3'h0;
    wdata_o = 8'h00;
  end
  // Callers wait for busy to clear; the one read while busy is a deliberate probe
  task automatic acc(input logic rd, input logic ctl, input logic [2:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(negedge ref_clk_i);
    cs0_n_o = ctl;
    cs1_n_o = !ctl;
    da_o = a;
    wdata_o = d;
    dior_n_o = !rd;
    diow_n_o = rd;
    repeat (6) @(posedge ref_clk_i);
    q = rdata_i;
    @(negedge ref_clk_i);
    {dior_n_o, diow_n_o} = 2'h3;
    repeat (6) @(negedge ref_clk_i);
    {cs0_n_o, cs1_n_o} = 2'h3;
    wdata_o = ~d;
  endtask
endmodule // host_port_model
`default_nettype wire

// *** taskfile_status_cmd_tb.sv ***
// Purpose: Self-checking bench for the task-file status and command block
// Assumes: Device 0 only, clock enable held high
// Notes:   Host pins come from host_port_model, back end is driven here
`include "taskfile_defs.vh"
`default_nettype none
module taskfile_status_cmd_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk_i = 0, srst_i = 1, ready_i = 0, on_track_i = 0, wr_err_i = 0;
  logic        cmd_done_i = 0, cmd_err_i = 0, xfer_rdy_i = 0;
  wire  logic  cs0_n, cs1_n, dior_n, diow_n, intrq, intrq_oe, cmd_start, soft_reset, err_abort;
  wire  logic  dd_oe;
  wire  logic [2:0]  da;
  wire  logic [1:0]  cmd_proto;
  wire  logic [7:0]  dd_w, dd_r;
  int          error_cnt = 0, compares = 0, cyc = 0, n_start = 0;
  logic [1:0]  st_proto;
  logic [7:0]  q;
  logic [7:0]  code_t [7] = '{8'h90, 8'h91, 8'hb0, 8'hb1, 8'hf9, 8'hc8, 8'h20};
  logic [7:0]  feat_t [7] = '{8'h00, 8'h00, 8'hd5, 8'hc3, 8'h02, 8'h00, 8'h00};
  logic [1:0]  prot_t [7] = '{2'h3, 2'h3, 2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
  taskfile_status_cmd u_taskfile_status_cmd (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .ce_i(1'b1), .cs0_n_i(cs0_n), .cs1_n_i(cs1_n), .da_i(da), .dior_n_i(dior_n),
    .diow_n_i(diow_n), .dd_i(dd_w), .dev_id_i(1'b0), .ready_i(ready_i),
    .cmd_done_i(cmd_done_i), .cmd_err_i(cmd_err_i), .xfer_rdy_i(xfer_rdy_i),
    .corrected_i(1'b0), .index_i(1'b0), .on_track_i(on_track_i), .wr_err_i(wr_err_i),
    .dd_o(dd_r), .dd_oe_o(dd_oe), .intrq_o(intrq), .intrq_oe_o(intrq_oe), .cmd_start_o(cmd_start),
    .cmd_code_o(), .cmd_proto_o(cmd_proto), .cmd_feat_o(), .cmd_count_o(), .cmd_sector_o(),
    .cmd_cyl_o(), .cmd_head_o(), .cmd_lba_o(), .err_abort_o(err_abort),
    .soft_reset_o(soft_reset));
  host_port_model u_host_port_model (.ref_clk_i(ref_clk_i), .rdata_i(dd_r), .cs0_n_o(cs0_n),
    .cs1_n_o(cs1_n), .da_o(da), .dior_n_o(dior_n), .diow_n_o(diow_n), .wdata_o(dd_w));
  initial begin
    forever #10 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic ctl, input logic [2:0] a, input logic [7:0] d);
    u_host_port_model.acc(1'b0, ctl, a, d, q);
  endtask
  task automatic rd(input logic ctl, input logic [2:0] a);
    u_host_port_model.acc(1'b1, ctl, a, 8'h00, q);
  endtask
  // Parameters go in before the code
  task automatic issue(input logic [7:0] feat, input logic [7:0] code);
    wr(1'b0, `TF_ERRFEAT, feat);
    wr(1'b0, `TF_STATCMD, code);
  endtask
  task automatic finish_cmd(input logic err);
    @(negedge ref_clk_i);
    cmd_done_i = 1'b1;
    cmd_err_i = err;
    @(negedge ref_clk_i);
    cmd_done_i = 1'b0;
    cmd_err_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Starts are one-cycle pulses, so latch them as they fly past
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cmd_start === 1'b1) begin
      n_start <= n_start + 1;
      st_proto <= cmd_proto;
    end
    if (cyc == 6000) begin
      error_cnt++;
      conclude;
    end
  end
  initial begin
    repeat (16) @(negedge ref_clk_i);
    srst_i = 1'b0;
    rd(1'b1, `TF_ALTCTL);
    chk(q, 8'h00);
    chk(dd_oe, 1'b0);
    ready_i = 1'b1;
    on_track_i = 1'b1;
    $display("test power_on done");
    issue(8'h00, 8'h90);
    chk(8'(n_start), 8'h01);
    rd(1'b0, `TF_CYLLO);
    chk(q[7], 1'b1);
    finish_cmd(1'b0);
    chk(intrq, 1'b1);
    rd(1'b1, `TF_ALTCTL);
    chk(q, 8'h50);
    chk(intrq, 1'b1);
    rd(1'b0, `TF_STATCMD);
    chk(q, 8'h50);
    chk(intrq, 1'b0);
    $display("test status done");
    for (int i = 0; i < 7; i++) begin
      issue(feat_t[i], code_t[i]);
      chk(8'(n_start), 8'(i + 2));
      chk(st_proto, prot_t[i]);
      finish_cmd(1'b0);
      rd(1'b0, `TF_STATCMD);
    end
    issue(8'h00, 8'h00);
    chk(err_abort, 1'b1);
    rd(1'b0, `TF_STATCMD);
    chk(q, 8'h51);
    $display("test decode done");
    issue(8'h00, 8'h90);
    finish_cmd(1'b1);
    on_track_i = 1'b0;
    rd(1'b1, `TF_ALTCTL);
    chk(q, 8'h51);
    rd(1'b0, `TF_STATCMD);
    wr_err_i = 1'b1;
    xfer_rdy_i = 1'b1;
    rd(1'b1, `TF_ALTCTL);
    chk(q & 8'hfe, 8'h68);
    $display("test error_hold done");
    wr(1'b1, `TF_ALTCTL, 8'h02);
    chk(intrq_oe, 1'b0);
    wr(1'b1, `TF_ALTCTL, 8'h00);
    chk(intrq_oe, 1'b1);
    wr(1'b0, `TF_DEVHEAD, 8'h10);
    chk(intrq_oe, 1'b0);
    wr(1'b0, `TF_DEVHEAD, 8'h00);
    wr(1'b1, `TF_ALTCTL, 8'h04);
    chk(soft_reset, 1'b1);
    issue(8'h00, 8'h90);
    chk(8'(n_start), 8'h09);
    wr(1'b1, `TF_ALTCTL, 8'h00);
    chk(soft_reset, 1'b0);
    $display("test control done");
    conclude;
  end
endmodule // taskfile_status_cmd_tb
`default_nettype wire
